// ==== flash_component_capability_regs.sv ====
/*
  Capability register group of a serial flash controller: two component
  capability registers, the parameter table observation window and the
  requester status view, plus the capability set steering the flash engine.
  Assumes a synchronous one-word memory register port and a discovery engine
  that delivers capability loads and table words as one-cycle strobes.
*/
`timescale 1ns/1ns

module flash_component_capability_regs (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  // memory register port
  input  wire logic                         reg_sel,
  input  wire logic                         reg_write,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  output logic                              reg_ack,
  output logic [31:0]                       reg_rdata,
  // discovery engine
  input  wire logic                         slave_attach_mode,
  input  wire flash_cap_pkg::cap_discovery_t discovery,
  input  wire flash_cap_pkg::table_fill_t    table_fill,
  // requester activity
  input  wire flash_cap_pkg::req_activity_t  req_activity [0:5],
  input  wire logic                         trusted_module_access_active,
  input  wire logic                         shared_bus_access_active,
  input  wire logic                         shared_bus_mode,
  // flash cycle capability lookup
  input  wire logic [26:0]                  cycle_addr,
  input  wire logic [26:0]                  comp0_size,
  output flash_cap_pkg::flash_caps_t         active_caps
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] cap_write(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic locked);
    logic [31:0] mask;
    mask = locked ? flash_cap_pkg::WORD_ZERO : flash_cap_pkg::LOCKABLE_MASK;
    return (old & ~mask) | (wdata & mask);
  endfunction : cap_write

  function automatic logic [2:0] req_code(input flash_cap_pkg::req_activity_t r);
    return r.active ? {1'b1, r.kind} : 3'h0;
  endfunction : req_code

  function automatic logic [4:0] table_slot(input logic [1:0] kind, input logic [9:0] ofs);
    logic [4:0] slot;
    slot = 5'(ofs);
    unique case (kind)
      flash_cap_pkg::KIND_SFDP_HDR:  slot = 5'(ofs);
      flash_cap_pkg::KIND_PARAM_HDR: slot = 5'(flash_cap_pkg::HDR_WORDS) + 5'(ofs);
      default:                       slot = 5'(2 * flash_cap_pkg::HDR_WORDS) + 5'(ofs);
    endcase
    return slot;
  endfunction : table_slot

  function automatic logic slot_ok(input logic [1:0] kind, input logic [9:0] ofs);
    unique case (kind)
      flash_cap_pkg::KIND_SFDP_HDR,
      flash_cap_pkg::KIND_PARAM_HDR: return ofs < 10'(flash_cap_pkg::HDR_WORDS);
      flash_cap_pkg::KIND_DATA:      return ofs < 10'(flash_cap_pkg::DATA_WORDS);
      default:                       return 1'b0;
    endcase
  endfunction : slot_ok

  // ----------------------------------------
  // capability registers
  // ----------------------------------------
  logic [31:0] cap0_reg;
  logic [31:0] cap1_reg;
  logic        bus_wr;
  logic        disc_ok;
  logic        cap0_locked;
  logic        cap1_locked;

  assign bus_wr      = reg_sel & reg_write;
  // no discovery in slave-attached mode
  assign disc_ok     = discovery.load & ~slave_attach_mode;
  assign cap0_locked = cap0_reg[flash_cap_pkg::TV_BIT] | cap0_reg[flash_cap_pkg::LOCK_BIT];
  assign cap1_locked = cap1_reg[flash_cap_pkg::TV_BIT] | cap0_reg[flash_cap_pkg::LOCK_BIT];

  // discovery outranks a software write landing in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap0_reg <= flash_cap_pkg::CAP_RESET;
    end else if (disc_ok && !discovery.comp) begin
      cap0_reg <= (discovery.caps & flash_cap_pkg::LOCKABLE_MASK)
                | (cap0_reg & (32'(1) << flash_cap_pkg::LOCK_BIT))
                | (32'(1) << flash_cap_pkg::TV_BIT);
    end else if (bus_wr && reg_addr == flash_cap_pkg::CAP0_OFS) begin
      // lock only ever rises; other fields follow the lock state
      cap0_reg <= cap_write(cap0_reg, reg_wdata, cap0_locked)
                | ((cap0_reg | reg_wdata) & (32'(1) << flash_cap_pkg::LOCK_BIT));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap1_reg <= flash_cap_pkg::CAP_RESET;
    end else if (disc_ok && discovery.comp) begin
      cap1_reg <= (discovery.caps & flash_cap_pkg::LOCKABLE_MASK)
                | (32'(1) << flash_cap_pkg::TV_BIT);
    end else if (bus_wr && reg_addr == flash_cap_pkg::CAP1_OFS) begin
      cap1_reg <= cap_write(cap1_reg, reg_wdata, cap1_locked);
    end
  end

  // ----------------------------------------
  // parameter table window
  // ----------------------------------------
  logic [31:0] index_reg;
  logic [31:0] table_mem [0:1][0:flash_cap_pkg::SLOTS-1];
  logic [1:0]  sel_table;
  logic [1:0]  sel_kind;
  logic [9:0]  sel_ofs;
  logic [31:0] window_word;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      index_reg <= flash_cap_pkg::WORD_ZERO;
    end else if (bus_wr && reg_addr == flash_cap_pkg::INDEX_OFS) begin
      index_reg <= reg_wdata & flash_cap_pkg::INDEX_MASK;
    end
  end

  // table storage has no reset; the window reads an unfilled word as whatever the memory holds
  always_ff @(posedge mclk) begin
    if (table_fill.write && !slave_attach_mode && slot_ok(table_fill.kind, table_fill.offset)) begin
      table_mem[table_fill.comp][table_slot(table_fill.kind, table_fill.offset)] <= table_fill.data;
    end
  end

  assign sel_table = index_reg[flash_cap_pkg::TABLE_SEL_LSB +: 2];
  assign sel_kind  = index_reg[flash_cap_pkg::KIND_LSB +: 2];
  assign sel_ofs   = index_reg[flash_cap_pkg::DW_OFS_LSB +: 10];

  always_comb begin
    window_word = flash_cap_pkg::WORD_ZERO;
    // reserved selections and slave-attached mode read as zero
    if (!slave_attach_mode && sel_table[1] == 1'b0 && slot_ok(sel_kind, sel_ofs)) begin
      window_word = table_mem[sel_table[0]][table_slot(sel_kind, sel_ofs)];
    end
  end

  // ----------------------------------------
  // requester status
  // ----------------------------------------
  logic [31:0] req_status_reg;
  logic [31:0] req_status_next;

  always_comb begin
    req_status_next = flash_cap_pkg::WORD_ZERO;
    for (int i = 0; i < flash_cap_pkg::NUM_REQ; i++) begin
      req_status_next[flash_cap_pkg::REQ_LSB[i] +: 3] = req_code(req_activity[i]);
    end
    req_status_next[flash_cap_pkg::TPM_BIT]    = trusted_module_access_active;
    req_status_next[flash_cap_pkg::SHARED_BIT] = shared_bus_mode & shared_bus_access_active;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_status_reg <= flash_cap_pkg::WORD_ZERO;
    end else begin
      req_status_reg <= req_status_next;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  logic [31:0] read_next;

  always_comb begin
    unique case (reg_addr)
      flash_cap_pkg::CAP0_OFS:  read_next = cap0_reg;
      flash_cap_pkg::CAP1_OFS:  read_next = cap1_reg;
      flash_cap_pkg::INDEX_OFS: read_next = index_reg;
      flash_cap_pkg::DATA_OFS:  read_next = window_word;
      flash_cap_pkg::REQ_OFS:   read_next = req_status_reg;
      default:                  read_next = flash_cap_pkg::WORD_ZERO;
    endcase
  end

  // every access answers one cycle later, writes with zero data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_ack   <= 1'b0;
      reg_rdata <= flash_cap_pkg::WORD_ZERO;
    end else begin
      reg_ack   <= reg_sel;
      reg_rdata <= (reg_sel && !reg_write) ? read_next : flash_cap_pkg::WORD_ZERO;
    end
  end

  // ----------------------------------------
  // capabilities of the addressed component
  // ----------------------------------------
  logic        in_comp0;
  logic [31:0] sel_cap;

  assign in_comp0 = cycle_addr < comp0_size;
  assign sel_cap  = in_comp0 ? cap0_reg : cap1_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_caps <= '0;
    end else begin
      active_caps.large_erase_usable        <= sel_cap[flash_cap_pkg::LARGE_OK_BIT];
      active_caps.small_erase_usable        <= sel_cap[flash_cap_pkg::SMALL_OK_BIT];
      active_caps.large_erase_opcode        <= sel_cap[flash_cap_pkg::LARGE_OP_LSB +: 8];
      active_caps.small_erase_opcode        <= sel_cap[flash_cap_pkg::SMALL_OP_LSB +: 8];
      active_caps.monotonic_counter_support <= sel_cap[flash_cap_pkg::COUNTER_BIT];
      active_caps.deep_sleep_support        <= sel_cap[flash_cap_pkg::SLEEP_BIT];
      active_caps.soft_reset_support        <= sel_cap[flash_cap_pkg::SOFT_RST_BIT];
      // component 0 stores this flag with opposite sense
      active_caps.suspend_support           <= sel_cap[flash_cap_pkg::SUSPEND_BIT] ^ in_comp0;
      active_caps.quad_enable_requirement   <= sel_cap[flash_cap_pkg::QER_LSB +: 3];
      active_caps.status_write_two_bytes    <= sel_cap[flash_cap_pkg::QER_LSB +: 3]
                                               == flash_cap_pkg::QER_SR2_CLEARS;
      // component 0 ignores status-write settings; granularity ignored everywhere
      active_caps.status_write_required     <= ~in_comp0 & sel_cap[flash_cap_pkg::STATUS_REQ_BIT];
      active_caps.status_prefix_opcode      <= (~in_comp0 & ~sel_cap[flash_cap_pkg::STATUS_EN_BIT])
                                               ? flash_cap_pkg::PREFIX_STATUS_EN
                                               : flash_cap_pkg::PREFIX_WRITE_EN;
      active_caps.preserve_quad_enable_bit  <= ~in_comp0 & sel_cap[flash_cap_pkg::STATUS_REQ_BIT]
                                               & (sel_cap[flash_cap_pkg::QER_LSB +: 3]
                                                  != flash_cap_pkg::QER_NONE);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  lock_sticky_a : assert property (@(posedge mclk) disable iff (!rst_n)
    cap0_reg[flash_cap_pkg::LOCK_BIT] |=> cap0_reg[flash_cap_pkg::LOCK_BIT])
    else $error("capability lock dropped");

  locked_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (cap0_locked && bus_wr && reg_addr == flash_cap_pkg::CAP0_OFS && !disc_ok)
    |=> (cap0_reg & flash_cap_pkg::LOCKABLE_MASK) == ($past(cap0_reg) & flash_cap_pkg::LOCKABLE_MASK))
    else $error("locked capability field changed");

  valid_set_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (discovery.load && !slave_attach_mode && discovery.comp)
    |=> cap1_reg[flash_cap_pkg::TV_BIT] ##1 cap1_reg[flash_cap_pkg::TV_BIT])
    else $error("table valid not set after discovery");

  slave_window_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_sel && !reg_write && reg_addr == flash_cap_pkg::DATA_OFS && slave_attach_mode)
    |=> reg_ack && reg_rdata == flash_cap_pkg::WORD_ZERO)
    else $error("window not empty in slave-attached mode");

  reserved_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_sel && !reg_write && (reg_addr == flash_cap_pkg::CAP0_OFS || reg_addr == flash_cap_pkg::INDEX_OFS))
    |=> reg_rdata[1:0] == 2'h0 ##1 !reg_ack || reg_rdata[1:0] == 2'h0)
    else $error("reserved bits read nonzero");

  idle_requester_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !req_activity[4].active |=> req_status_reg[17:15] == 3'h0)
    else $error("idle requester shows activity");

  counter_code_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (req_activity[5].active && req_activity[5].kind == 2'h3) |=> req_status_reg[14:12] == 3'h7)
    else $error("monotonic counter code wrong");

  suspend_sense_a : assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(rst_n) && in_comp0) |=> active_caps.suspend_support != $past(cap0_reg[flash_cap_pkg::SUSPEND_BIT]))
    else $error("component 0 suspend sense not inverted");

  comp1_prefix_a : assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(rst_n) && !in_comp0 && !cap1_reg[flash_cap_pkg::STATUS_EN_BIT])
    |=> active_caps.status_prefix_opcode == flash_cap_pkg::PREFIX_STATUS_EN)
    else $error("status write prefix wrong for component 1");

  ack_follow_a : assert property (@(posedge mclk) disable iff (!rst_n)
    reg_sel |=> reg_ack)
    else $error("register access not acknowledged");

  tpm_flag_a : assert property (@(posedge mclk) disable iff (!rst_n)
    trusted_module_access_active |=> req_status_reg[flash_cap_pkg::TPM_BIT])
    else $error("trusted module activity not shown");

  shared_gate_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (shared_bus_access_active && !shared_bus_mode) |=> !req_status_reg[flash_cap_pkg::SHARED_BIT])
    else $error("shared bus flag shown outside shared mode");

  comp0_status_a : assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(rst_n) && in_comp0)
    |=> active_caps.status_prefix_opcode == flash_cap_pkg::PREFIX_WRITE_EN
        && !active_caps.status_write_required && !active_caps.preserve_quad_enable_bit)
    else $error("component 0 status write settings not ignored");

  two_byte_a : assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(rst_n) && sel_cap[flash_cap_pkg::QER_LSB +: 3] == flash_cap_pkg::QER_SR2_CLEARS)
    |=> active_caps.status_write_two_bytes)
    else $error("two-byte status write not requested");

  reserved_table_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_sel && !reg_write && reg_addr == flash_cap_pkg::DATA_OFS && sel_table[1])
    |=> reg_rdata == flash_cap_pkg::WORD_ZERO)
    else $error("reserved table selection not empty");

endmodule : flash_component_capability_regs

// ==== flash_cap_pkg.sv ====
/*
  Shared constants and carriers for the flash component capability registers.
  Assumes a word-wide memory register port with byte offsets as listed here.
*/
package flash_cap_pkg;

  // ----------------------------------------
  // register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0]  CAP0_OFS      = 8'hc4;
  localparam logic [7:0]  CAP1_OFS      = 8'hc8;
  localparam logic [7:0]  INDEX_OFS     = 8'hcc;
  localparam logic [7:0]  DATA_OFS      = 8'hd0;
  localparam logic [7:0]  REQ_OFS       = 8'hd4;
  localparam logic [31:0] CAP_RESET     = 32'h0000_2000;
  localparam logic [31:0] LOCKABLE_MASK = 32'h3fff_fffc;
  localparam logic [31:0] INDEX_MASK    = 32'h0000_fffc;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TV_BIT         = 31;
  localparam int LOCK_BIT       = 30;
  localparam int LARGE_OK_BIT   = 29;
  localparam int SMALL_OK_BIT   = 28;
  localparam int COUNTER_BIT    = 27;
  localparam int SLEEP_BIT      = 26;
  localparam int SUSPEND_BIT    = 25;
  localparam int SOFT_RST_BIT   = 24;
  localparam int LARGE_OP_LSB   = 16;
  localparam int SMALL_OP_LSB   = 8;
  localparam int QER_LSB        = 5;
  localparam int STATUS_EN_BIT  = 4;
  localparam int STATUS_REQ_BIT = 3;
  localparam int TABLE_SEL_LSB  = 14;
  localparam int KIND_LSB       = 12;
  localparam int DW_OFS_LSB     = 2;
  localparam int TPM_BIT        = 31;
  localparam int SHARED_BIT     = 30;
  localparam int NUM_REQ        = 6;
  localparam int REQ_LSB [0:5]  = '{0, 3, 6, 9, 15, 12};

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [7:0] PREFIX_STATUS_EN = 8'h50;
  localparam logic [7:0] PREFIX_WRITE_EN  = 8'h06;
  localparam logic [2:0] QER_NONE         = 3'h0;
  localparam logic [2:0] QER_SR2_CLEARS   = 3'h1;
  localparam logic [1:0] TABLE_COMP0      = 2'h0;
  localparam logic [1:0] TABLE_COMP1      = 2'h1;
  localparam logic [1:0] KIND_SFDP_HDR    = 2'h0;
  localparam logic [1:0] KIND_PARAM_HDR   = 2'h1;
  localparam logic [1:0] KIND_DATA        = 2'h2;
  localparam int         HDR_WORDS        = 2;
  localparam int         DATA_WORDS       = 16;
  localparam int         SLOTS            = 2 * HDR_WORDS + DATA_WORDS;
  localparam int         ADDR_W           = 27;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  // kind: 00 read, 01 write, 10 erase, 11 monotonic counter
  typedef struct packed {
    logic       active;
    logic [1:0] kind;
  } req_activity_t;

  // caps uses the capability register layout, bits 29:2
  typedef struct packed {
    logic        load;
    logic        comp;
    logic [31:0] caps;
  } cap_discovery_t;

  typedef struct packed {
    logic        write;
    logic        comp;
    logic [1:0]  kind;
    logic [9:0]  offset;
    logic [31:0] data;
  } table_fill_t;

  typedef struct packed {
    logic       large_erase_usable;
    logic       small_erase_usable;
    logic [7:0] large_erase_opcode;
    logic [7:0] small_erase_opcode;
    logic       monotonic_counter_support;
    logic       deep_sleep_support;
    logic       suspend_support;
    logic       soft_reset_support;
    logic [2:0] quad_enable_requirement;
    logic       status_write_required;
    logic [7:0] status_prefix_opcode;
    logic       status_write_two_bytes;
    logic       preserve_quad_enable_bit;
  } flash_caps_t;

endpackage : flash_cap_pkg

// ==== flash_discovery_model.sv ====
/*
  Behavioural discovery engine facing the capability register group:
  delivers capability loads and parameter table words as one-cycle strobes.
  Assumes the bench calls its tasks from one sequential process.
*/
`timescale 1ns/1ns

module flash_discovery_model (
  // clock
  input  wire logic                     mclk,
  // strobes toward the register group
  output flash_cap_pkg::cap_discovery_t discovery,
  output flash_cap_pkg::table_fill_t    table_fill
);
  initial begin
    discovery  = '0;
    table_fill = '0;
  end

  // --------------------------------
  // strobes
  // --------------------------------
  // stale payload is inverted after the pulse so a late sample cannot pass
  task automatic load_caps(input logic comp, input logic [31:0] caps);
    @(posedge mclk);
    discovery <= '{1'b1, comp, caps};
    @(posedge mclk);
    discovery <= '{1'b0, comp, ~caps};
  endtask : load_caps

  task automatic fill_word(input logic comp, input logic [1:0] kind,
                           input logic [9:0] ofs, input logic [31:0] data);
    @(posedge mclk);
    table_fill <= '{1'b1, comp, kind, ofs, data};
    @(posedge mclk);
    table_fill <= '{1'b0, comp, kind, ofs, ~data};
  endtask : fill_word
endmodule : flash_discovery_model

// ==== flash_component_capability_regs_tb.sv ====
/*
  Self-checking bench for the flash component capability registers.
  Assumes the discovery model file and the design package are compiled first.
*/
`timescale 1ns/1ns

module flash_component_capability_regs_tb;
  logic                           mclk, nrst, reg_sel, reg_write, reg_ack;
  logic                           slave_attach_mode, trust_act, shared_act, shared_mode;
  logic [7:0]                     reg_addr;
  logic [31:0]                    reg_wdata, reg_rdata;
  logic [26:0]                    cycle_addr, comp0_size;
  flash_cap_pkg::req_activity_t   req_act [0:5];
  flash_cap_pkg::cap_discovery_t  discovery;
  flash_cap_pkg::table_fill_t     table_fill;
  flash_cap_pkg::flash_caps_t     active_caps;
  int                             err_total, tests_run;

  flash_component_capability_regs i_flash_component_capability_regs (
    .mclk(mclk), .nrst(nrst), .reg_sel(reg_sel), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .slave_attach_mode(slave_attach_mode), .discovery(discovery), .table_fill(table_fill),
    .req_activity(req_act), .trusted_module_access_active(trust_act),
    .shared_bus_access_active(shared_act), .shared_bus_mode(shared_mode),
    .cycle_addr(cycle_addr), .comp0_size(comp0_size), .active_caps(active_caps));

  flash_discovery_model i_flash_discovery_model (
    .mclk(mclk), .discovery(discovery), .table_fill(table_fill));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held to the taking edge; answer looked at in its one cycle
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    reg_sel   <= 1'b1;
    reg_write <= w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_sel <= 1'b0;
    #1;
    chk({35'h0, reg_ack}, 36'h1);
    q = reg_rdata;
  endtask : rw

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rw(1'b0, a, 32'h0000_0000, q);
    chk({4'h0, q}, {4'h0, exp});
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    rw(1'b1, a, d, q);
  endtask : wr

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset;
    rd_chk(8'hc4, 32'h0000_2000);
    rd_chk(8'hc8, 32'h0000_2000);
    rd_chk(8'hcc, 32'h0000_0000);
    rd_chk(8'hd4, 32'h0000_0000);
    rd_chk(8'hd8, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_discovery;
    i_flash_discovery_model.load_caps(1'b1, 32'h2a5a_202c);
    rd_chk(8'hc8, 32'haa5a_202c);
    wr(8'hc8, 32'haa5a_202c);
    wr(8'hc8, 32'h0000_0000);
    rd_chk(8'hc8, 32'haa5a_202c);
    $display("test discovery done");
  endtask : t_discovery

  task automatic t_caps;
    wr(8'hc4, 32'h22d8_3028);
    @(posedge mclk);
    comp0_size <= 27'h100_0000;
    cycle_addr <= 27'h0ff_ffff;
    repeat (3) @(posedge mclk);
    chk(active_caps, {2'b10, 16'hd830, 4'b0000, 3'h1, 1'b0, 8'h06, 2'b10});
    cycle_addr <= 27'h100_0000;
    repeat (3) @(posedge mclk);
    chk(active_caps, {2'b10, 16'h5a20, 4'b1010, 3'h1, 1'b1, 8'h50, 2'b11});
    wr(8'hc4, 32'h27d8_3088);
    @(posedge mclk);
    cycle_addr <= 27'h0ff_ffff;
    repeat (3) @(posedge mclk);
    chk(active_caps, {2'b10, 16'hd830, 4'b0101, 3'h4, 1'b0, 8'h06, 2'b00});
    $display("test caps done");
  endtask : t_caps

  task automatic t_window;
    i_flash_discovery_model.fill_word(1'b1, 2'h2, 10'h003, 32'h1357_9bdf);
    i_flash_discovery_model.fill_word(1'b0, 2'h0, 10'h001, 32'ha5a5_0f0f);
    i_flash_discovery_model.fill_word(1'b1, 2'h1, 10'h000, 32'h0f1e_2d3c);
    wr(8'hcc, 32'h0000_600c);
    rd_chk(8'hcc, 32'h0000_600c);
    rd_chk(8'hd0, 32'h1357_9bdf);
    wr(8'hcc, 32'h0000_0004);
    rd_chk(8'hd0, 32'ha5a5_0f0f);
    wr(8'hcc, 32'h0000_5000);
    rd_chk(8'hd0, 32'h0f1e_2d3c);
    wr(8'hcc, 32'hffff_800f);
    rd_chk(8'hcc, 32'h0000_800c);
    rd_chk(8'hd0, 32'h0000_0000);
    wr(8'hcc, 32'h0000_700c);
    rd_chk(8'hd0, 32'h0000_0000);
    wr(8'hcc, 32'h0000_600c);
    @(posedge mclk);
    slave_attach_mode <= 1'b1;
    rd_chk(8'hd0, 32'h0000_0000);
    @(posedge mclk);
    slave_attach_mode <= 1'b0;
    $display("test window done");
  endtask : t_window

  task automatic t_requester;
    @(posedge mclk);
    req_act     <= '{'{1'b1, 2'h0}, '{1'b1, 2'h1}, '{1'b1, 2'h2}, '{1'b1, 2'h3}, '{1'b0, 2'h2}, '{1'b1, 2'h3}};
    trust_act   <= 1'b1;
    shared_act  <= 1'b1;
    shared_mode <= 1'b1;
    rd_chk(8'hd4, 32'hc000_7fac);
    @(posedge mclk);
    req_act[4]  <= '{1'b1, 2'h2};
    trust_act   <= 1'b0;
    shared_mode <= 1'b0;
    rd_chk(8'hd4, 32'h0003_7fac);
    $display("test requester done");
  endtask : t_requester

  task automatic t_lock;
    wr(8'hc4, 32'h4000_0000);
    rd_chk(8'hc4, 32'h4000_0000);
    wr(8'hc4, 32'h3fff_fffc);
    rd_chk(8'hc4, 32'h4000_0000);
    $display("test lock done");
  endtask : t_lock

  task automatic final_report;
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // --------------------------------
  // sequence and watchdog
  // --------------------------------
  initial begin
    #40000;
    err_total++;
    final_report();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    nrst = 1'b0;
    reg_sel = 1'b0;
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    slave_attach_mode = 1'b0;
    trust_act = 1'b0;
    shared_act = 1'b0;
    shared_mode = 1'b0;
    cycle_addr = 27'h000_0000;
    comp0_size = 27'h000_0000;
    req_act = '{default: '0};
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_discovery();
    t_caps();
    t_window();
    t_requester();
    t_lock();
    final_report();
  end
endmodule : flash_component_capability_regs_tb
